// ### logic/atsd_pkg.sv
// package: register map, field layout and timing constants for the trim/swap/dither bank
package atsd_pkg;

  // ----------------------------------------------------------------
  // register indices (printed offsets) and byte addresses
  // ----------------------------------------------------------------
  localparam logic [9:0]  IDX_TERM_TRIM      = 10'h081;
  localparam logic [9:0]  IDX_SRC_OVERLAP    = 10'h09A;
  localparam logic [9:0]  IDX_STEER_DELAY    = 10'h09B;
  localparam logic [9:0]  IDX_DITHER_CTRL    = 10'h09D;
  localparam int          ADDR_WIDTH         = 12;

  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_TERM_TRIM      = 8'h00;
  localparam logic [7:0]  RST_SRC_OVERLAP    = 8'h08;
  localparam logic [7:0]  RST_STEER_DELAY    = 8'h07;
  localparam logic [7:0]  RST_DITHER_CTRL    = 8'h00;
  localparam int          DELAY_FIELD_MSB    = 4;
  localparam int          DITH_EN_BIT        = 0;
  localparam int          DITH_AMP_BIT       = 1;
  localparam int          DITH_ERR_BIT       = 2;

  // ----------------------------------------------------------------
  // swap timing: overlap = base + 2 * field, in sample-clock cycles
  // ----------------------------------------------------------------
  localparam logic [6:0]  OVERLAP_BASE       = 7'h04;
  localparam logic [1:0]  AXI_RESP_OKAY      = 2'h0;
  localparam logic [1:0]  AXI_RESP_SLVERR    = 2'h2;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              awvalid;
    logic [ADDR_WIDTH-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_WIDTH-1:0] araddr;
    logic              rready;
  } atsd_axi_req_type;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } atsd_axi_rsp_type;

  typedef struct packed {
    logic [7:0]        term_trim;
    logic [4:0]        swap_source_overlap_delay;
    logic [4:0]        swap_steering_select_delay;
    logic              dither_enable;
    logic              dither_amplitude_select;
    logic              dither_rounding_error_select;
  } atsd_cfg_type;

  typedef enum logic [1:0] {
    SWAP_IDLE    = 2'b00,
    SWAP_OVERLAP = 2'b01,
    SWAP_STEER   = 2'b10
  } atsd_swap_state_type;

  // byte address -> register index, or all-ones if unmapped
  function automatic logic [2:0] atsd_decode(input logic [ADDR_WIDTH-1:0] addr);
    logic [9:0] idx;
    idx = addr[ADDR_WIDTH-1:2];
    if (addr[1:0] != 2'h0)
      atsd_decode = 3'h7;
    else if (idx == IDX_TERM_TRIM)
      atsd_decode = 3'h0;
    else if (idx == IDX_SRC_OVERLAP)
      atsd_decode = 3'h1;
    else if (idx == IDX_STEER_DELAY)
      atsd_decode = 3'h2;
    else if (idx == IDX_DITHER_CTRL)
      atsd_decode = 3'h3;
    else
      atsd_decode = 3'h7;
  endfunction

endpackage

// ### logic/atsd_delay_line.sv
// programmable delay of the steering select, in sample-clock cycles
`timescale 1ns/1ps
module atsd_delay_line #(
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // control
  input  wire logic       swap_active,
  input  wire logic [4:0] delay,
  input  wire logic       sel_in,
  // result
  output logic            sel_out
);
  import atsd_pkg::*;

  logic [DEPTH-1:0] tap;

  // ----------------------------------------------------------------
  // shift register of select history
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      tap <= '0;
    else
      tap <= {tap[DEPTH-2:0], sel_in};
  end

  // delay only during swaps; otherwise the select passes straight
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      sel_out <= 1'b0;
    else if (!swap_active || delay == 5'h00)
      sel_out <= sel_in;
    else
      sel_out <= tap[delay - 5'h01];
  end

endmodule // atsd_delay_line

// ### logic/atsd_swap_seq.sv
// swap sequencer: overlap window then delayed stream changeover
`timescale 1ns/1ps
module atsd_swap_seq (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // control
  input  wire logic       swap_request,
  input  wire logic [4:0] overlap_delay,
  // status
  output logic            both_cores_sampling,
  output logic            swap_active,
  output logic            steer_raw
);
  import atsd_pkg::*;

  atsd_swap_state_type state;
  logic [6:0]          count;
  logic [6:0]          overlap_len;

  assign overlap_len = OVERLAP_BASE + {1'b0, overlap_delay, 1'b0};

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state     <= SWAP_IDLE;
      count     <= 7'h00;
      steer_raw <= 1'b0;
    end
    else
    begin
      case (state)
        SWAP_IDLE:
        begin
          if (swap_request)
          begin
            state <= SWAP_OVERLAP;
            count <= overlap_len;
          end
        end
        SWAP_OVERLAP:
        begin
          if (count == 7'h01)
          begin
            state     <= SWAP_STEER;
            steer_raw <= ~steer_raw;
          end
          count <= count - 7'h01;
        end
        SWAP_STEER:
          state <= SWAP_IDLE;
        default:
          state <= SWAP_IDLE;
      endcase
    end
  end

  // overlap lasts exactly overlap_len cycles
  assign both_cores_sampling = (state == SWAP_OVERLAP);
  assign swap_active         = (state != SWAP_IDLE);

endmodule // atsd_swap_seq

// ### logic/atsd_regs.sv
// trim, swap timing and dither register bank with AXI4-Lite slave
//
// Functional notes
// - eight-bit read/write termination trim for input pair four drives trim output directly
// - trim loads from fuse value after reset; readable and overwritable
// - both cores sample together for four plus twice overlap field; field resets eight
// - overlap field accepts any value zero through thirty-one
// - five-bit steering delay, reset seven, applied only during swaps
// - delayed steering select drives core-to-encoder multiplexers
// - steering delay field accepts any value zero through thirty-one
// - dither control bit zero enables dither; resets clear
// - dither control bit one picks small or large dither amplitude
// - dither control bit two picks rounding error into noise or offset/spurs
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module atsd_regs (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // register bus
  input  wire atsd_pkg::atsd_axi_req_type axi_req,
  output atsd_pkg::atsd_axi_rsp_type      axi_rsp,
  // fuse storage
  input  wire logic                       fuse_valid,
  input  wire logic [7:0]                 fuse_term_trim,
  // swap sequencing
  input  wire logic                       swap_request,
  input  wire logic                       steer_select_in,
  output logic                            both_cores_sampling,
  output logic                            swap_active,
  output logic                            steer_select,
  // configuration out
  output atsd_pkg::atsd_cfg_type          cfg
);
  import atsd_pkg::*;

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [7:0] term_trim;
  logic [7:0] src_overlap;
  logic [7:0] steer_delay;
  logic [7:0] dither_ctrl;
  logic       fuse_loaded;

  // ----------------------------------------------------------------
  // write channel capture
  // ----------------------------------------------------------------
  logic                  aw_held;
  logic                  w_held;
  logic [ADDR_WIDTH-1:0] aw_addr;
  logic [7:0]            w_byte;
  logic                  w_lane0;
  logic                  bvalid;
  logic [1:0]            bresp;
  logic                  do_write;
  logic [2:0]            wr_sel;

  assign axi_rsp.awready = !aw_held && !bvalid;
  assign axi_rsp.wready  = !w_held && !bvalid;
  assign axi_rsp.bvalid  = bvalid;
  assign axi_rsp.bresp   = bresp;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end
    else if (axi_req.awvalid && axi_rsp.awready)
    begin
      aw_held <= 1'b1;
      aw_addr <= axi_req.awaddr;
    end
    else if (do_write)
      aw_held <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      w_held  <= 1'b0;
      w_byte  <= 8'h00;
      w_lane0 <= 1'b0;
    end
    else if (axi_req.wvalid && axi_rsp.wready)
    begin
      w_held  <= 1'b1;
      w_byte  <= axi_req.wdata[7:0];
      w_lane0 <= axi_req.wstrb[0];
    end
    else if (do_write)
      w_held <= 1'b0;
  end

  // commit once both halves are captured
  assign do_write = aw_held && w_held;
  assign wr_sel   = atsd_decode(aw_addr);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      bvalid <= 1'b0;
      bresp  <= AXI_RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid <= 1'b1;
      bresp  <= (wr_sel == 3'h7) ? AXI_RESP_SLVERR : AXI_RESP_OKAY;
    end
    else if (axi_req.bready)
      bvalid <= 1'b0;
  end

  // ----------------------------------------------------------------
  // fuse load
  // ----------------------------------------------------------------
  // fuse data may arrive late; a software write before it lands wins
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      fuse_loaded <= 1'b0;
    else if (fuse_valid || (do_write && wr_sel == 3'h0 && w_lane0))
      fuse_loaded <= 1'b1;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      term_trim <= RST_TERM_TRIM;
    else if (do_write && wr_sel == 3'h0 && w_lane0)
      term_trim <= w_byte;
    else if (!fuse_loaded && fuse_valid)
      term_trim <= fuse_term_trim;
  end

  // full byte stored, reserved bits too; any 0..31 accepted
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      src_overlap <= RST_SRC_OVERLAP;
    else if (do_write && wr_sel == 3'h1 && w_lane0)
      src_overlap <= w_byte;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      steer_delay <= RST_STEER_DELAY;
    else if (do_write && wr_sel == 3'h2 && w_lane0)
      steer_delay <= w_byte;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      dither_ctrl <= RST_DITHER_CTRL;
    else if (do_write && wr_sel == 3'h3 && w_lane0)
      dither_ctrl <= w_byte;
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  logic        rvalid;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic [2:0]  rd_sel;
  logic [7:0]  rd_byte;

  assign axi_rsp.arready = !rvalid;
  assign axi_rsp.rvalid  = rvalid;
  assign axi_rsp.rdata   = rdata;
  assign axi_rsp.rresp   = rresp;
  assign rd_sel          = atsd_decode(axi_req.araddr);

  // reserved bits read back as stored
  always_comb
  begin
    case (rd_sel)
      3'h0:    rd_byte = term_trim;
      3'h1:    rd_byte = src_overlap;
      3'h2:    rd_byte = steer_delay;
      3'h3:    rd_byte = dither_ctrl;
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= AXI_RESP_OKAY;
    end
    else if (axi_req.arvalid && axi_rsp.arready)
    begin
      rvalid <= 1'b1;
      rdata  <= {24'h000000, rd_byte};
      rresp  <= (rd_sel == 3'h7) ? AXI_RESP_SLVERR : AXI_RESP_OKAY;
    end
    else if (axi_req.rready)
      rvalid <= 1'b0;
  end

  // ----------------------------------------------------------------
  // configuration outputs
  // ----------------------------------------------------------------
  // fields come straight from storage; reserved bits are not decoded
  assign cfg.term_trim                    = term_trim;
  assign cfg.swap_source_overlap_delay    = src_overlap[DELAY_FIELD_MSB:0];
  assign cfg.swap_steering_select_delay   = steer_delay[DELAY_FIELD_MSB:0];
  assign cfg.dither_enable                = dither_ctrl[DITH_EN_BIT];
  assign cfg.dither_amplitude_select      = dither_ctrl[DITH_AMP_BIT];
  assign cfg.dither_rounding_error_select = dither_ctrl[DITH_ERR_BIT];

  // ----------------------------------------------------------------
  // swap sequencing and steering delay
  // ----------------------------------------------------------------
  // overlap field is assumed stable: software only moves it with calibration off
  atsd_swap_seq u_swap_seq (
    .clk                 (clk),
    .rst_n               (rst_n),
    .swap_request        (swap_request),
    .overlap_delay       (src_overlap[DELAY_FIELD_MSB:0]),
    .both_cores_sampling (both_cores_sampling),
    .swap_active         (swap_active),
    .steer_raw           ()
  );

  // delayed select steers core outputs to encoders
  atsd_delay_line #(
    .DEPTH (32)
  ) u_delay_line (
    .clk         (clk),
    .rst_n       (rst_n),
    .swap_active (swap_active),
    .delay       (steer_delay[DELAY_FIELD_MSB:0]),
    .sel_in      (steer_select_in),
    .sel_out     (steer_select)
  );

endmodule // atsd_regs

// ### sim/atsd_regs_props.sv
// checker: bus timing, swap window and steering assertions
`timescale 1ns/1ps
module atsd_regs_props (
  // clock and reset
  input wire logic                       clk,
  input wire logic                       rst_n,
  // register bus
  input wire atsd_pkg::atsd_axi_req_type axi_req,
  input wire atsd_pkg::atsd_axi_rsp_type axi_rsp,
  // swap and configuration
  input wire logic                       swap_request,
  input wire logic                       steer_select_in,
  input wire logic                       both_cores_sampling,
  input wire logic                       swap_active,
  input wire logic                       steer_select,
  input wire atsd_pkg::atsd_cfg_type     cfg
);
  import atsd_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // helper: length of the running overlap window
  // ----------------------------------------------------------------
  logic [6:0] run;
  always_ff @(posedge clk)
  begin
    if (!rst_n || !both_cores_sampling)
      run <= 7'h00;
    else
      run <= run + 7'h01;
  end

  // ----------------------------------------------------------------
  // helper: history of the raw steer select, newest in bit 0
  // ----------------------------------------------------------------
  logic [31:0] hist;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      hist <= '0;
    else
      hist <= {hist[30:0], steer_select_in};
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_CORE_WINDOW:
    assert property ($fell(both_cores_sampling) |->
      run == OVERLAP_BASE + {1'b0, cfg.swap_source_overlap_delay, 1'b0})
    else $error("overlap window length wrong");
  AST_SWAP_START:
    assert property (swap_request && !swap_active |=> both_cores_sampling)
    else $error("swap did not start");
  AST_STEER_CYCLE:
    assert property ($fell(both_cores_sampling) |-> swap_active ##1 !swap_active)
    else $error("steer cycle missing");
  AST_CORES_IN_SWAP:
    assert property (both_cores_sampling |-> swap_active)
    else $error("overlap outside swap");
  AST_STEER_IDLE:
    assert property ($past(rst_n) && !swap_active && !$past(swap_active) |->
      steer_select == $past(steer_select_in))
    else $error("steer delay applied outside swap");
  AST_STEER_SWAP:
    assert property ($past(rst_n) && $past(swap_active) |->
      steer_select == hist[$past(cfg.swap_steering_select_delay)])
    else $error("steer delay wrong during swap");
  AST_RD_LAT:
    assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read answer late");
  AST_WR_LAT:
    assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
      |-> ##2 axi_rsp.bvalid)
    else $error("write answer late");
  AST_R_HOLD:
    assert property (axi_rsp.rvalid && !axi_req.rready |=>
      axi_rsp.rvalid && $stable(axi_rsp.rdata) && $stable(axi_rsp.rresp))
    else $error("read answer dropped");
  AST_RESET_CFG:
    assert property ($rose(rst_n) |-> cfg.swap_source_overlap_delay == 5'h08 &&
      cfg.swap_steering_select_delay == 5'h07 && !cfg.dither_enable &&
      !cfg.dither_amplitude_select && !cfg.dither_rounding_error_select)
    else $error("reset configuration wrong");

  cover property ($fell(both_cores_sampling));
  cover property (axi_rsp.rvalid && !axi_req.rready);
  cover property (axi_rsp.bvalid && axi_rsp.bresp == AXI_RESP_SLVERR);
endmodule // atsd_regs_props

bind atsd_regs atsd_regs_props u_props (
  .clk                 (clk),
  .rst_n               (rst_n),
  .axi_req             (axi_req),
  .axi_rsp             (axi_rsp),
  .swap_request        (swap_request),
  .steer_select_in     (steer_select_in),
  .both_cores_sampling (both_cores_sampling),
  .swap_active         (swap_active),
  .steer_select        (steer_select),
  .cfg                 (cfg)
);

// ### sim/tb_top.sv
// testbench: register access, fuse load and swap window checks
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
  import atsd_pkg::*;
  logic             clk = 1'b0;
  logic             rst_n = 1'b0;
  atsd_axi_req_type req = '0;
  atsd_axi_rsp_type rsp;
  logic             fuse_valid = 1'b0;
  logic [7:0]       fuse_term_trim = 8'h00;
  logic             swap_request = 1'b0;
  logic             steer_select_in = 1'b0;
  logic             both_cores_sampling;
  logic             swap_active;
  logic             steer_select;
  atsd_cfg_type     cfg;
  int               errors = 0;
  int               n_tests = 0;
  int               cyc = 0;
  int               r;
  int               n;
  logic [31:0]      seed = 32'h0000EEB4;
  logic [7:0]       mdl [4];
  logic [7:0]       d;
  logic [31:0]      rdat;
  logic [1:0]       resp;
  localparam logic [9:0] IDX [4] = '{IDX_TERM_TRIM, IDX_SRC_OVERLAP, IDX_STEER_DELAY, IDX_DITHER_CTRL};
  localparam logic [7:0] RSTV [4] = '{RST_TERM_TRIM, RST_SRC_OVERLAP, RST_STEER_DELAY, RST_DITHER_CTRL};
  // reserved bits always written as their reset value of zero
  localparam logic [7:0] MSK [4] = '{8'hFF, 8'h1F, 8'h1F, 8'h07};

  atsd_regs u_dut (
    .clk                 (clk),
    .rst_n               (rst_n),
    .axi_req             (req),
    .axi_rsp             (rsp),
    .fuse_valid          (fuse_valid),
    .fuse_term_trim      (fuse_term_trim),
    .swap_request        (swap_request),
    .steer_select_in     (steer_select_in),
    .both_cores_sampling (both_cores_sampling),
    .swap_active         (swap_active),
    .steer_select        (steer_select),
    .cfg                 (cfg)
  );

  // ----------------------------------------------------------------
  // clock, random source, raw steer select, timeout
  // ----------------------------------------------------------------
  always #25 clk = ~clk;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  always @(posedge clk)
  begin
    steer_select_in <= ^xs();
    cyc++;
    if (cyc == 5000)
    begin
      errors++;
      end_of_test();
    end
  end

  function automatic atsd_cfg_type exp_cfg();
    atsd_cfg_type c;
    c.term_trim = mdl[0];
    c.swap_source_overlap_delay = mdl[1][4:0];
    c.swap_steering_select_delay = mdl[2][4:0];
    c.dither_enable = mdl[3][DITH_EN_BIT];
    c.dither_amplitude_select = mdl[3][DITH_AMP_BIT];
    c.dither_rounding_error_select = mdl[3][DITH_ERR_BIT];
    return c;
  endfunction

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= {24'h0, v};
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge clk);
      if (!aw_ok && rsp.awready === 1'b1)
      begin
        aw_ok = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (!w_ok && rsp.wready === 1'b1)
      begin
        w_ok = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (rsp.bvalid !== 1'b1);
    resp = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    do @(posedge clk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    // late rready exercises the held answer
    repeat (xs() % 3) @(posedge clk);
    req.rready <= 1'b1;
    do @(posedge clk); while (rsp.rvalid !== 1'b1);
    rdat = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (r = 0; r < 4; r++)
    begin
      mdl[r] = RSTV[r];
      rd({IDX[r], 2'h0});
      `CHK(rdat, {24'h0, RSTV[r]})
    end
    // only the first fuse strobe loads the trim
    d = 8'(xs());
    fuse_term_trim <= d;
    fuse_valid <= 1'b1;
    @(posedge clk);
    fuse_valid <= 1'b0;
    fuse_term_trim <= ~d;
    @(posedge clk);
    fuse_valid <= 1'b1;
    @(posedge clk);
    fuse_valid <= 1'b0;
    mdl[0] = d;
    rd({IDX[0], 2'h0});
    `CHK(rdat, {24'h0, d})
    `CHK(cfg, exp_cfg())
    for (int i = 0; i < 24; i++)
    begin
      r = (i < 4) ? i : int'(xs() % 4);
      d = (i < 4) ? 8'hFF : 8'(xs());
      d = d & MSK[r];
      wr({IDX[r], 2'h0}, d);
      mdl[r] = d;
      `CHK(resp, AXI_RESP_OKAY)
      rd({IDX[r], 2'h0});
      `CHK(rdat, {24'h0, d})
      `CHK(cfg, exp_cfg())
    end
    // unmapped and misaligned places
    rd(12'h208);
    `CHK(resp, AXI_RESP_SLVERR)
    `CHK(rdat, 32'h0)
    rd(12'h205);
    `CHK(resp, AXI_RESP_SLVERR)
    wr(12'h300, 8'h5A);
    `CHK(resp, AXI_RESP_SLVERR)
    `CHK(cfg, exp_cfg())
    for (int k = 0; k < 3; k++)
    begin
      d = (k == 0) ? 8'h00 : (k == 1) ? 8'h1F : (8'(xs()) & 8'h1F);
      wr({IDX[1], 2'h0}, d);
      mdl[1] = d;
      // vary the steering delay too, so the swap-time delay is exercised
      wr({IDX[2], 2'h0}, 8'h1F - d);
      mdl[2] = 8'h1F - d;
      `CHK(resp, AXI_RESP_OKAY)
      @(posedge clk);
      swap_request <= 1'b1;
      @(posedge clk);
      swap_request <= 1'b0;
      n = 0;
      repeat (80)
      begin
        @(posedge clk);
        if (both_cores_sampling === 1'b1)
          n++;
      end
      `CHK(n, int'(OVERLAP_BASE) + 2 * int'(d))
    end
    end_of_test();
  end
endmodule // tb_top
